// ==== dv/pmic_spi_register_port_bench.sv ====
// Bench: host and device ends joined, plus a bench-driven second device
`timescale 1ns/10ps
module pmic_spi_register_port_bench;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic req_i = 1'h0;
  logic req_write_i = 1'h0;
  logic [5:0] req_addr_i = 6'h00;
  logic [23:0] req_data_i = 24'h00_0000;
  logic busy_o, done_o;
  logic [23:0] rd_data_o, d2;
  logic [23:0] mask = 24'h00_0000;
  logic [23:0] mem [64];
  logic [31:0] wmosi, wmiso, cap, r;
  logic oe;
  integer seed = 32'h0000_72dd;
  int mismatches, comparisons, cycles, strobes1, strobes2, writes;
  psrp_link_if link();
  psrp_link_if link2();
  psrp_host psrp_host_i (.clk_i(clk_i), .reset_i(reset_i), .link(link), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i),
    .busy_o(busy_o), .done_o(done_o), .rd_data_o(rd_data_o));
  psrp_device psrp_device_i (.clk_i(clk_i), .reset_i(reset_i), .link(link),
    .used_mask_i(mask), .hw_set_i(24'h00_0000), .hw_set_addr_i(6'h00),
    .mode_two_wire_o(), .address_select_bit_o(), .mode_valid_o(), .wr_strobe_o(),
    .wr_addr_o(), .wr_data_o());
  // Second device faces the bench, which can break the frame on purpose
  psrp_device psrp_device_fault_i (.clk_i(clk_i), .reset_i(reset_i), .link(link2),
    .used_mask_i(mask), .hw_set_i(24'h00_0000), .hw_set_addr_i(6'h00),
    .mode_two_wire_o(), .address_select_bit_o(), .mode_valid_o(), .wr_strobe_o(),
    .wr_addr_o(), .wr_data_o());
  psrp_link_asserts psrp_link_asserts_i (.clk_i(clk_i), .reset_i(reset_i),
    .sclk(link.sclk), .cs(link.cs), .mosi(link.mosi), .miso_out(link.miso_out),
    .miso_oe(link.miso_oe));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge link.sclk) begin
    wmosi <= {wmosi[30:0], link.mosi};
    wmiso <= {wmiso[30:0], link.miso_out};
  end
  always @(negedge clk_i) begin
    strobes1 += int'(psrp_device_i.wr_strobe_o === 1'h1);
    strobes2 += int'(psrp_device_fault_i.wr_strobe_o === 1'h1);
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic host_op(input logic w, input logic [5:0] a, input logic [23:0] d);
    int n;
    n = 0;
    {req_i, req_write_i, req_addr_i, req_data_i} = {1'h1, w, a, d};
    while (busy_o !== 1'h1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    req_i = 1'h0;
    while (done_o !== 1'h1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    if (done_o !== 1'h1) begin
      mismatches++;
      $display("Error at %0t: host transfer timed out", $time);
    end
    chk(rd_data_o, mem[a]);
    chk(wmiso[23:0], mem[a]);
    chk({wmiso[31:24], 16'h0000}, 24'h00_0000);
    chk({wmosi[31:25], 17'h0_0000}, {w, a, 17'h0_0000});
    if (w) begin
      mem[a] = d & mask;
      writes++;
      chk({18'h0_0000, psrp_device_i.wr_addr_o}, {18'h0_0000, a});
      chk(wmosi[23:0], d);
      chk(psrp_device_i.wr_data_o & mask, mem[a]);
    end
  endtask
  // Bench acts as host on the second link; n below 32 cuts the frame short
  task automatic bang(input int n, input logic [31:0] fr);
    oe = 1'h0;
    link2.cs = 1'h1;
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      link2.mosi = fr[31-i];
      repeat (8) @(negedge clk_i);
      link2.sclk = 1'h1;
      cap = {cap[30:0], link2.miso_out};
      oe = oe | link2.miso_oe;
      repeat (8) @(negedge clk_i);
      link2.sclk = 1'h0;
    end
    repeat (8) @(negedge clk_i);
    link2.cs = 1'h0;
    link2.mosi = ~link2.mosi;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {link2.sclk, link2.cs, link2.mosi} = 3'h0;
    mask = 24'($random(seed));
    for (int i = 0; i < 64; i++) mem[i] = 24'h00_0000;
    repeat (3) @(negedge clk_i);
    reset_i = 1'h0;
    repeat (4) @(negedge clk_i);
    repeat (40) begin
      r = $random(seed);
      host_op(r[4], {{3{r[3]}}, r[2:0]}, r[31:8]);
    end
    chk(24'(strobes1), 24'(writes));
    $display("test random_ops done");
    chk({21'h00_0000, psrp_device_fault_i.mode_two_wire_o,
      psrp_device_fault_i.mode_valid_o, 1'h0}, 24'h00_0002);
    d2 = 24'($random(seed));
    bang(32, {1'h1, 6'h2a, 1'h0, d2});
    chk(psrp_device_fault_i.wr_data_o & mask, d2 & mask);
    chk({18'h0_0000, psrp_device_fault_i.wr_addr_o}, 24'h00_002a);
    bang(20, {1'h1, 6'h2a, 1'h0, ~d2});
    bang(32, {1'h0, 6'h2a, 1'h0, ~d2});
    chk(cap[23:0], d2 & mask);
    chk({cap[31:24], 15'h0000, oe}, 24'h00_0001);
    chk(24'(strobes2), 24'h00_0001);
    $display("test fault_frames done");
    {link2.cs, link2.mosi, reset_i} = 3'h7;
    repeat (4) @(negedge clk_i);
    reset_i = 1'h0;
    repeat (4) @(negedge clk_i);
    chk({21'h00_0000, psrp_device_fault_i.mode_two_wire_o,
      psrp_device_fault_i.address_select_bit_o, psrp_device_fault_i.mode_valid_o},
      24'h00_0007);
    bang(32, {1'h1, 6'h2a, 1'h0, d2});
    chk({23'h00_0000, oe}, 24'h00_0000);
    chk(24'(strobes2), 24'h00_0001);
    $display("test two_wire_strap done");
    conclude();
  end
endmodule // pmic_spi_register_port_bench

// ==== dv/psrp_link_asserts.sv ====
// Checks on the link between host and device ends
`timescale 1ns/10ps
module psrp_link_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link
  input wire logic sclk,
  input wire logic cs,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic [5:0] rises;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Rising link clock edges in this frame
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) rises <= 6'h00;
    else if (!cs) rises <= 6'h00;
    else if ($rose(sclk)) rises <= rises + 6'h01;
  end
  AST_FRAME_LEN: assert property ($fell(cs) |-> rises == 6'h20)
    else $error("frame length is not 32 clocks");
  AST_CS_GAP: assert property ($fell(cs) |-> !cs [*4])
    else $error("select gap too short");
  AST_CS_HOLD: assert property ($fell(cs) |-> !sclk && !$past(sclk, 4))
    else $error("select dropped too soon after last fall");
  AST_CS_SETUP: assert property ($rose(cs) |-> !sclk [*4])
    else $error("clock rose too soon after select");
  AST_MOSI_STABLE: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("data in moved at clock rise");
  AST_MISO_STABLE: assert property ($rose(sclk) && miso_oe |-> $stable(miso_out))
    else $error("data out moved at clock rise");
  AST_MISO_HEADER: assert property (cs && miso_oe && rises < 6'h08 |-> !miso_out)
    else $error("data out not zero in header");
  AST_MISO_OFF: assert property (!cs [*6] |-> !miso_oe)
    else $error("data out driven while deselected");
  AST_MISO_ON: assert property ($rose(cs) |-> ##[1:8] miso_oe)
    else $error("data out not enabled in frame");
  cover property ($fell(cs) && rises == 6'h20);
  cover property ($rose(miso_oe));
  cover property (miso_oe && miso_out);
endmodule // psrp_link_asserts

// ==== verilog/psrp_device.sv ====
// Device end: strap latch, frame decode and 64 x 24 register map
`timescale 1ns/10ps
`include "psrp_params.svh"
// Notes on behaviour
// RQ1: Latch chip select at start; low means serial
// RQ2: Chip select high at start selects two-wire mode
// RQ3: Two-wire mode reuses clock, data; data-in gives address; the code only latches the address bit and accepts no frames in two-wire mode
// RQ4: Mode fixed before any frame is accepted
// RQ5: Frame: direction, six address, dead, 24 data
// RQ6: Map holds 64 registers of 24 bits
// RQ7: First bit one writes, zero reads
// RQ8: Address sent MSB first, then dead bit
// RQ9: Header bits captured on serial clock rise
// RQ10: Data driven on fall, sampled on rise
// RQ11: Read frame ignores data, changes nothing
// RQ12: Write loads register on 32nd falling edge
// RQ13: Write frame shifts out old register contents
// RQ14: Early chip select drop discards the write
// RQ15: Host holds select after last falling edge
// RQ16: Host toggles select low between frames
// RQ17: Data out released while select low
// RQ18: Host writes zeros to unused bits; the host sends req_data_i as given and only the device masks unused bits
// RQ19: Read-back zeros address field, unused bits
// RQ20: Bits may be rw, ro, w1c, clear-on-read
// RQ21: Counter and shifter cleared while select low
module psrp_device #(
  parameter int REG_COUNT = `PSRP_REG_COUNT
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  // Link
  psrp_link_if.device                    link,
  // Register map user side
  input  wire logic [`PSRP_DATA_W-1:0]   used_mask_i,
  input  wire logic [`PSRP_DATA_W-1:0]   hw_set_i,
  input  wire logic [`PSRP_ADDR_W-1:0]   hw_set_addr_i,
  output logic                           mode_two_wire_o,
  output logic                           address_select_bit_o,
  output logic                           mode_valid_o,
  output logic                           wr_strobe_o,
  output logic [`PSRP_ADDR_W-1:0]        wr_addr_o,
  output logic [`PSRP_DATA_W-1:0]        wr_data_o
);
  // Synchronisers: stage one only feeds stage two
  logic [1:0]                    sclk_s;
  logic [1:0]                    cs_s;
  logic [1:0]                    mosi_s;
  logic                          sclk_d;
  logic                          strap_done;
  logic [1:0]                    strap_wait;
  logic [5:0]                    bit_cnt;
  logic [6:0]                    hdr;
  logic                          is_write;
  logic [`PSRP_DATA_W-1:0]       rx_data;
  logic [`PSRP_DATA_W-1:0]       tx_data;
  logic                          miso_q;
  logic                          miso_oe_q;
  logic [`PSRP_DATA_W-1:0]       regs [REG_COUNT];

  // Unimplemented bits are neither stored by writes nor returned; the hardware set path can still store them
  function automatic logic [`PSRP_DATA_W-1:0] masked(
    input logic [`PSRP_DATA_W-1:0] word,
    input logic [`PSRP_DATA_W-1:0] keep
  );
    return word & keep;
  endfunction

  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  wire cs_on     = cs_s[1] & strap_done & ~mode_two_wire_o;
  // Synchroniser holds its reset value for two edges; strap must wait for it
  wire strap_ready = (strap_wait == `PSRP_STRAP_SETTLE);
  wire [`PSRP_ADDR_W-1:0] hdr_addr = hdr[`PSRP_ADDR_W-1:0];
  wire [`PSRP_DATA_W-1:0] rd_word  = masked(regs[hdr_addr], used_mask_i);
  wire [`PSRP_DATA_W-1:0] wr_word  = masked(rx_data, used_mask_i);
  wire [`PSRP_DATA_W-1:0] set_word = regs[hw_set_addr_i] | hw_set_i;
  wire at_dir    = (bit_cnt == `PSRP_DIR_POS);
  wire in_addr   = (bit_cnt < `PSRP_ADDR_END);
  wire in_data   = (bit_cnt >= `PSRP_HDR_BITS);
  wire hdr_last  = (bit_cnt == `PSRP_HDR_BITS) && sclk_fall;
  wire frame_end = (bit_cnt == `PSRP_FRAME_BITS) && sclk_fall;
  // Write only when the frame ran its full length under select
  wire commit    = cs_on && frame_end && is_write;

  assign link.miso_out = miso_q;
  assign link.miso_oe  = miso_oe_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_s <= 2'b00;
      cs_s   <= 2'b00;
      mosi_s <= 2'b00;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], link.sclk};
      cs_s   <= {cs_s[0], link.cs};
      mosi_s <= {mosi_s[0], link.mosi};
      sclk_d <= sclk_s[1];
    end
  end

  // RQ4 settle count before strap
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_wait <= 2'h0;
    end else if (!strap_ready) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  // RQ1 strap capture once synchroniser filled
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_done           <= 1'b0;
      mode_two_wire_o      <= 1'b0;
      address_select_bit_o <= 1'b0;
      mode_valid_o         <= 1'b0;
    end else if (!strap_done && strap_ready) begin
      strap_done           <= 1'h1;
      mode_valid_o         <= 1'b1;
      // RQ2 high strap selects
      mode_two_wire_o      <= cs_s[1];
      // RQ3 address select strap
      address_select_bit_o <= mosi_s[1];
    end
  end

  // RQ4 frames gated by strap
  // RQ21 clear when deselected
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt  <= 6'd0;
      hdr      <= `PSRP_ADDR_LO;
      is_write <= 1'b0;
      rx_data  <= `PSRP_ZERO_DATA;
    end else if (!cs_on) begin
      bit_cnt  <= 6'd0;
      hdr      <= `PSRP_ADDR_LO;
      is_write <= 1'b0;
      rx_data  <= `PSRP_ZERO_DATA;
    end else if (sclk_rise && bit_cnt < `PSRP_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 6'h01;
      // RQ9 header on rise
      // RQ7 direction bit
      if (at_dir) begin
        is_write <= mosi_s[1];
      // RQ8 address MSB first
      end else if (in_addr) begin
        hdr <= {hdr[`PSRP_ADDR_W-1:0], mosi_s[1]};
      end else if (in_data) begin
        // RQ12 data MSB first
        rx_data <= {rx_data[`PSRP_DATA_W-2:0], mosi_s[1]};
      end
    end
  end

  // RQ10 drive on falling edge
  // RQ13 old value also for writes
  // RQ19 zero header and unused
  // RQ17 release when deselected
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_data   <= `PSRP_ZERO_DATA;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (!cs_on) begin
      tx_data   <= `PSRP_ZERO_DATA;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= 1'b1;
      if (hdr_last) begin
        miso_q  <= rd_word[`PSRP_DATA_W-1];
        tx_data <= {rd_word[`PSRP_DATA_W-2:0], 1'b0};
      end else if (sclk_fall && bit_cnt > `PSRP_HDR_BITS) begin
        miso_q  <= tx_data[`PSRP_DATA_W-1];
        tx_data <= {tx_data[`PSRP_DATA_W-2:0], 1'b0};
      end else if (sclk_fall && bit_cnt < `PSRP_HDR_BITS) begin
        miso_q  <= 1'b0;
      end
    end
  end

  // RQ6 64-entry map; RQ20 access kinds left to owning logic
  // RQ12 commit on 32nd fall
  // RQ11 reads change nothing
  // RQ14 early drop never reaches frame_end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= `PSRP_ZERO_DATA;
      end
      wr_strobe_o <= 1'b0;
      wr_addr_o   <= '0;
      wr_data_o   <= `PSRP_ZERO_DATA;
    end else begin
      wr_strobe_o <= 1'h0;
      if (commit) begin
        regs[hdr_addr] <= wr_word;
        wr_strobe_o    <= 1'h1;
        wr_addr_o      <= hdr_addr;
        wr_data_o      <= wr_word;
      end else begin
        // Hardware status bits: set-only until a software write, which loads the written word
        regs[hw_set_addr_i] <= set_word;
      end
    end
  end
endmodule // psrp_device

// ==== verilog/psrp_host.sv ====
// Host end: serial master that makes the link clock from clk_i
`timescale 1ns/10ps
`include "psrp_params.svh"
module psrp_host (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // Link
  psrp_link_if.host                     link,
  // Request
  input  wire logic                     req_i,
  input  wire logic                     req_write_i,
  input  wire logic [`PSRP_ADDR_W-1:0]  req_addr_i,
  input  wire logic [`PSRP_DATA_W-1:0]  req_data_i,
  // Answer
  output logic                          busy_o,
  output logic                          done_o,
  output logic [`PSRP_DATA_W-1:0]       rd_data_o
);
  psrp_pkg::psrp_host_state_t state;
  logic [7:0]  div;
  logic [5:0]  bit_cnt;
  logic [31:0] sh;
  logic [1:0]  miso_s;
  logic [1:0]  miso_en_s;
  logic        sclk_q;
  logic        cs_q;

  wire half = (div == `PSRP_CLK_DIV - 8'd1);
  // A released data line reads as its pull-down level
  wire miso_bit = miso_s[1] & miso_en_s[1];
  assign link.sclk = sclk_q;
  assign link.cs   = cs_q;
  assign link.mosi = sh[31];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      miso_s    <= 2'h0;
      miso_en_s <= 2'h0;
    end else begin
      miso_s    <= {miso_s[0], link.miso_out};
      miso_en_s <= {miso_en_s[0], link.miso_oe};
    end
  end

  // Frame: select, 32 clocks, hold, deselect gap before next (RQ16)
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state     <= psrp_pkg::PSRP_IDLE;
      div       <= 8'd0;
      bit_cnt   <= 6'd0;
      sh        <= 32'h0000_0000;
      sclk_q    <= 1'b0;
      cs_q      <= 1'b0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      rd_data_o <= `PSRP_ZERO_DATA;
    end else begin
      done_o <= 1'b0;
      div    <= half ? 8'd0 : div + 8'd1;
      unique case (state)
        psrp_pkg::PSRP_IDLE: begin
          if (req_i && !busy_o) begin
            // RQ5 RQ7 RQ8 frame layout; RQ18 wants unused bits zero, req_data_i goes out as given
            sh      <= {req_write_i, req_addr_i, 1'b0, req_data_i};
            cs_q    <= 1'b1;
            busy_o  <= 1'b1;
            bit_cnt <= 6'd0;
            div     <= 8'd0;
            state   <= psrp_pkg::PSRP_SHIFT;
          end
        end
        psrp_pkg::PSRP_SHIFT: begin
          if (half) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              sh      <= {sh[30:0], 1'b0};
              bit_cnt <= bit_cnt + 6'd1;
              if (bit_cnt == `PSRP_FRAME_BITS - 6'd1) begin
                state <= psrp_pkg::PSRP_HOLD;
              end
            end else if (bit_cnt >= `PSRP_HDR_BITS) begin
              // RQ10 sample data on rise
              rd_data_o <= {rd_data_o[`PSRP_DATA_W-2:0], miso_bit};
            end
          end
        end
        psrp_pkg::PSRP_HOLD: begin
          // RQ15 hold select after last fall
          if (half) begin
            if (cs_q) begin
              cs_q <= 1'b0;
            end else begin
              busy_o <= 1'b0;
              done_o <= 1'b1;
              state  <= psrp_pkg::PSRP_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule // psrp_host

// ==== verilog/psrp_link_if.sv ====
// Serial link between host master and device port
`timescale 1ns/10ps
interface psrp_link_if;
  logic sclk;
  logic cs;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  modport device (
    input  sclk,
    input  cs,
    input  mosi,
    output miso_out,
    output miso_oe
  );
  modport host (
    output sclk,
    output cs,
    output mosi,
    input  miso_out,
    input  miso_oe
  );
endinterface

// ==== verilog/psrp_params.svh ====
// Timing counts, frame layout and reset values for the serial register port
`ifndef PSRP_PARAMS_SVH
`define PSRP_PARAMS_SVH
`define PSRP_FRAME_BITS    6'h20
`define PSRP_HDR_BITS      6'h08
`define PSRP_DIR_POS       6'h00
`define PSRP_ADDR_END      6'h07
`define PSRP_STRAP_SETTLE  2'h2
`define PSRP_ADDR_W        6
`define PSRP_DATA_W        24
`define PSRP_REG_COUNT     64
`define PSRP_CLK_DIV       8'h08
`define PSRP_CS_GAP        8'h04
`define PSRP_ZERO_DATA     24'h00_0000
`define PSRP_ADDR_LO       7'h00
`endif

// ==== verilog/psrp_pkg.sv ====
// Shared types for the serial register port
package psrp_pkg;
  typedef enum logic [1:0] {
    PSRP_IDLE,
    PSRP_SHIFT,
    PSRP_HOLD
  } psrp_host_state_t;
  typedef enum logic [1:0] {
    PSRP_ACC_RW,
    PSRP_ACC_RO,
    PSRP_ACC_W1C,
    PSRP_ACC_COR
  } psrp_access_t;
endpackage
